// ### hw/fsc_pkg.sv
// shared constants, types and register map of the forced stop controller
package fsc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_METHOD  = 8'h00;
   localparam logic [7:0] ADDR_TORQUE  = 8'h04;
   localparam logic [7:0] ADDR_DECEL   = 8'h08;
   localparam logic [7:0] ADDR_CONFIG  = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int METHOD_LSB = 4;
   localparam int METHOD_W   = 4;
   localparam logic [15:0] METHOD_RST = 16'h0010;
   localparam logic [15:0] TORQUE_RST = 16'h0320;
   localparam logic [15:0] TORQUE_MAX = 16'h0320;
   localparam logic [15:0] DECEL_RST  = 16'h0000;
   localparam logic [15:0] DECEL_MAX  = 16'h2710;
   // config: bit0 input assigned, bit1 coast (else brake) in the hold state after the stop; coast methods outside torque mode always coast there
   localparam int CFG_ASSIGN = 0;
   localparam int CFG_COAST  = 1;
   localparam logic [1:0] CFG_RST = 2'h0;
   // interrupt events: bit0 stop entered, bit1 hold state entered
   localparam int IRQ_W = 2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ     = 50_000_000;
   localparam int DECEL_UNIT_US = 1000;
   localparam int CYC_PER_MS = CLK_HZ / 1_000_000 * DECEL_UNIT_US;

   typedef enum logic [2:0]
   {
      FSC_BRAKE_OR_COAST,
      FSC_TORQ_THEN_SOFF,
      FSC_TORQ_THEN_COAST,
      FSC_TIME_THEN_SOFF,
      FSC_TIME_THEN_COAST
   } fsc_method_t;

   typedef enum logic [1:0]
   {
      FSC_DRV_RUN,
      FSC_DRV_DECEL,
      FSC_DRV_BRAKE,
      FSC_DRV_COAST
   } fsc_drive_t;

   typedef struct packed
   {
      fsc_drive_t  drive;
      logic [15:0] torque_ceiling;
      logic [15:0] speed_ref;
      logic        panel_code;
   } fsc_cmd_t;

   function automatic logic [15:0] fsc_min16(input logic [15:0] a,
                                             input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

endpackage

// ### hw/fsc_ramp.sv
// speed ramp that falls to zero over a time scaled to maximum speed
`timescale 1ns/1ps
module fsc_ramp
   import fsc_pkg::*;
#(
   parameter int SPEED_W = 16
)
(
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   // control
   input  wire logic               i_load,
   input  wire logic               i_run,
   input  wire logic [SPEED_W-1:0] i_speed,
   input  wire logic [SPEED_W-1:0] i_max_speed,
   input  wire logic [15:0]        i_time_ms,
   // result
   output logic [SPEED_W-1:0]      o_speed,
   output logic                    o_zero
);
   logic [31:0] tick_cnt;
   logic [31:0] tick_len;
   logic        tick;

   // one speed unit is removed every (time*cycles_per_ms / max_speed)
   // cycles, so the full ramp from max speed takes the set time
   always_comb
   begin
      tick_len = (i_max_speed == '0) ? 32'h1 :
         32'(({16'h0, i_time_ms} * 32'(CYC_PER_MS)) / 32'(i_max_speed));
      if (tick_len == 32'h0)
         tick_len = 32'h1;
      tick = (tick_cnt + 32'h1 >= tick_len);
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         tick_cnt <= 32'h0;
      else if (i_load || !i_run || tick)
         tick_cnt <= 32'h0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_speed <= '0;
      else if (i_load)
         o_speed <= (i_time_ms == 16'h0) ? '0 : i_speed;
      else if (i_run && tick && o_speed != '0)
         o_speed <= o_speed - SPEED_W'(1);
   end

   assign o_zero = (o_speed == '0);
endmodule

// ### hw/fsc_sync.sv
// three-stage synchroniser with edge pulse for the forced stop input
`timescale 1ns/1ps
module fsc_sync
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // data
   input  wire logic i_d,
   output logic      o_q,
   output logic      o_fall
);
   logic meta;
   logic q2;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta <= 1'b1;
         q2   <= 1'b1;
         o_q  <= 1'b1;
      end
      else
      begin
         meta <= i_d;
         q2   <= meta;
         o_q  <= q2;
      end
   end

   // one pulse per falling transition, taken from stages after the first
   assign o_fall = o_q & ~q2;
endmodule

// ### hw/fsc_top.sv
// forced stop supervisor with AHB-Lite register access
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module fsc_top
   import fsc_pkg::*;
#(
   parameter int SPEED_W = 16
)
(
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   // AHB-Lite slave
   input  wire logic               i_hsel,
   input  wire logic [31:0]        i_haddr,
   input  wire logic [1:0]         i_htrans,
   input  wire logic               i_hwrite,
   input  wire logic [2:0]         i_hsize,
   input  wire logic [31:0]        i_hwdata,
   input  wire logic               i_hready,
   output logic [31:0]             o_hrdata,
   output logic                    o_hreadyout,
   output logic                    o_hresp,
   // drive side
   input  wire logic               i_forced_stop_in,
   input  wire logic               i_servo_on,
   input  wire logic               i_restart,
   input  wire logic               i_torque_mode,
   input  wire logic [SPEED_W-1:0] i_motor_speed,
   input  wire logic [SPEED_W-1:0] i_max_speed,
   input  wire logic [15:0]        i_motor_max_torque,
   // commands out
   output fsc_cmd_t                o_cmd,
   output logic                    o_forced_stop_active,
   output logic                    o_panel_forced_stop_code,
   output logic                    o_irq
);
   if (SPEED_W < 2 || SPEED_W > 16)
      $error("fsc_top: SPEED_W must be 2..16");

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0]      forced_stop_method_select;
   logic [15:0]      emergency_stop_torque_limit;
   logic [15:0]      stop_deceleration_time;
   logic [1:0]       config_bits;
   fsc_method_t      method_live;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_enable;

   // ----------------------------------------------------------------
   // bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   logic       ph_wr;
   logic [7:0] ph_addr;
   logic       take;

   assign take = i_hsel && i_hready && i_htrans[1];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ph_wr   <= 1'b0;
         ph_addr <= 8'h00;
      end
      else
      begin
         ph_wr   <= take && i_hwrite;
         ph_addr <= i_haddr[7:0];
      end
   end

   logic wr_clr;
   assign wr_clr = ph_wr && ph_addr == ADDR_IRQ_CLR;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         forced_stop_method_select   <= METHOD_RST;
         emergency_stop_torque_limit <= TORQUE_RST;
         stop_deceleration_time      <= DECEL_RST;
         config_bits                 <= CFG_RST;
         irq_enable                  <= '0;
      end
      else if (ph_wr)
      begin
         case (ph_addr)
            ADDR_METHOD:
               forced_stop_method_select <= i_hwdata[15:0];
            ADDR_TORQUE:
               emergency_stop_torque_limit <=
                  fsc_min16(i_hwdata[15:0], TORQUE_MAX);
            ADDR_DECEL:
               stop_deceleration_time <=
                  fsc_min16(i_hwdata[15:0], DECEL_MAX);
            ADDR_CONFIG:
               config_bits <= i_hwdata[1:0];
            ADDR_IRQ_EN:
               irq_enable <= i_hwdata[IRQ_W-1:0];
            default:
               config_bits <= config_bits;
         endcase
      end
   end

   // method field is only taken into use at reset or restart
   logic [METHOD_W-1:0] meth_field;
   assign meth_field =
      forced_stop_method_select[METHOD_LSB +: METHOD_W];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         method_live <= FSC_TORQ_THEN_SOFF;
      else if (i_restart)
      begin
         case (meth_field)
            4'h0:    method_live <= FSC_BRAKE_OR_COAST;
            4'h2:    method_live <= FSC_TORQ_THEN_COAST;
            4'h3:    method_live <= FSC_TIME_THEN_SOFF;
            4'h4:    method_live <= FSC_TIME_THEN_COAST;
            default: method_live <= FSC_TORQ_THEN_SOFF;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic stop_in_s;

   fsc_sync u_sync
   (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_d    (i_forced_stop_in),
      .o_q    (stop_in_s),
      .o_fall ()
   );

   logic assigned;
   logic stop_req;
   assign assigned = config_bits[CFG_ASSIGN];
   // open contact (low) requests a stop; unassigned input ignored
   assign stop_req = assigned && !stop_in_s;

   // ----------------------------------------------------------------
   // stop state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_RUN,
      ST_TORQ,
      ST_TIME,
      ST_HOLD,
      ST_BASE
   } fsc_state_t;

   fsc_state_t state;
   fsc_state_t next_state;
   logic       latched;
   logic       servo_on_d;
   logic       ramp_load;
   logic       ramp_zero;
   logic [SPEED_W-1:0] ramp_speed;
   logic       motor_zero;

   assign motor_zero = (i_motor_speed == '0);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         servo_on_d <= 1'b0;
      else
         servo_on_d <= i_servo_on;
   end

   // latch: set by a stop while servo is on, cleared only by
   // servo-on going off (base block) and coming back with input closed
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         latched <= 1'b0;
      else if (stop_req && i_servo_on)
         latched <= 1'b1;
      else if (!servo_on_d && i_servo_on && !stop_req)
         latched <= 1'b0;
   end

   always_comb
   begin
      next_state = state;
      ramp_load  = 1'b0;
      case (state)
         ST_RUN:
         begin
            if (stop_req || latched)
            begin
               if (i_torque_mode ||
                   method_live == FSC_BRAKE_OR_COAST)
                  next_state = ST_HOLD;
               else if (method_live == FSC_TIME_THEN_SOFF ||
                        method_live == FSC_TIME_THEN_COAST)
               begin
                  next_state = ST_TIME;
                  ramp_load  = 1'b1;
               end
               else
                  next_state = ST_TORQ;
            end
         end
         ST_TORQ:
            if (motor_zero)
               next_state = ST_HOLD;
         ST_TIME:
            if (ramp_zero && motor_zero)
               next_state = ST_HOLD;
         ST_HOLD:
            if (!i_servo_on)
               next_state = ST_BASE;
            else if (!latched && !stop_req)
               next_state = ST_RUN;
         ST_BASE:
            if (i_servo_on && !latched && !stop_req)
               next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         state <= ST_RUN;
      else
         state <= next_state;
   end

   fsc_ramp #(.SPEED_W(SPEED_W)) u_ramp
   (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_load      (ramp_load),
      .i_run       (state == ST_TIME),
      .i_speed     (i_motor_speed),
      .i_max_speed (i_max_speed),
      .i_time_ms   (stop_deceleration_time),
      .o_speed     (ramp_speed),
      .o_zero      (ramp_zero)
   );

   // ----------------------------------------------------------------
   // command outputs
   // ----------------------------------------------------------------
   logic coast_after;
   logic stopping;
   assign coast_after = (!i_torque_mode &&
                         (method_live == FSC_TORQ_THEN_COAST ||
                          method_live == FSC_TIME_THEN_COAST)) ?
                        1'b1 : config_bits[CFG_COAST];
   assign stopping = (state != ST_RUN);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_cmd <= '{FSC_DRV_RUN, 16'h0, 16'h0, 1'b0};
         o_forced_stop_active     <= 1'b0;
         o_panel_forced_stop_code <= 1'b0;
      end
      else
      begin
         o_cmd.panel_code         <= stopping;
         o_forced_stop_active     <= stopping;
         o_panel_forced_stop_code <= stopping;
         o_cmd.speed_ref <= 16'(ramp_speed);
         o_cmd.torque_ceiling <= fsc_min16(emergency_stop_torque_limit,
                                 i_motor_max_torque);
         case (state)
            ST_RUN:  o_cmd.drive <= FSC_DRV_RUN;
            ST_TORQ: o_cmd.drive <= FSC_DRV_DECEL;
            ST_TIME: o_cmd.drive <= FSC_DRV_DECEL;
            ST_HOLD: o_cmd.drive <= coast_after ? FSC_DRV_COAST :
                                                  FSC_DRV_BRAKE;
            ST_BASE: o_cmd.drive <= FSC_DRV_COAST;
            default: o_cmd.drive <= FSC_DRV_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupts: set wins over clear
   // ----------------------------------------------------------------
   logic [IRQ_W-1:0] irq_set;
   assign irq_set = {state != ST_HOLD && next_state == ST_HOLD,
                     state == ST_RUN && next_state != ST_RUN};

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~(wr_clr ?
                        i_hwdata[IRQ_W-1:0] : '0)) | irq_set;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_irq <= 1'b0;
      else
         o_irq <= |(irq_status & irq_enable);
   end

   // ----------------------------------------------------------------
   // read data, registered in the address phase
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_hrdata <= 32'h0;
      else if (take && !i_hwrite)
      begin
         case (i_haddr[7:0])
            ADDR_METHOD: o_hrdata <= {16'h0, forced_stop_method_select};
            ADDR_TORQUE: o_hrdata <= {16'h0, emergency_stop_torque_limit};
            ADDR_DECEL:  o_hrdata <= {16'h0, stop_deceleration_time};
            ADDR_CONFIG: o_hrdata <= {30'h0, config_bits};
            ADDR_STATUS: o_hrdata <= {24'h0, stop_in_s, latched,
                                      state, method_live};
            ADDR_IRQ_ST: o_hrdata <= {30'h0, irq_status};
            ADDR_IRQ_EN: o_hrdata <= {30'h0, irq_enable};
            default:     o_hrdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         {o_hreadyout, o_hresp} <= 2'b10;
      else
         {o_hreadyout, o_hresp} <= 2'b10;
   end
endmodule

// ### testbench/fsc_host_model.sv
// host controller, stop switch and motor seen from the drive
`timescale 1ns/1ps
module fsc_host_model
   import fsc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // bench requests
   input  wire logic        i_open,
   input  wire logic        i_servo_req,
   input  wire logic [15:0] i_run_speed,
   input  wire fsc_cmd_t    i_cmd,
   // toward the drive
   output logic             o_forced_stop_in,
   output logic             o_servo_on,
   output logic [15:0]      o_motor_speed
);
   // normally closed contact: a broken wire reads as a stop
   assign o_forced_stop_in = !i_open;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         o_servo_on <= 1'b0;
      else
         o_servo_on <= i_servo_req;

   // motor slows one step a cycle, and drops at once to the ramp value when that is lower
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         o_motor_speed <= 16'h0000;
      else if (i_cmd.drive == FSC_DRV_RUN)
         o_motor_speed <= i_run_speed;
      else if (i_cmd.drive == FSC_DRV_DECEL && i_cmd.speed_ref < o_motor_speed)
         o_motor_speed <= i_cmd.speed_ref;
      else if (o_motor_speed != 16'h0000)
         o_motor_speed <= o_motor_speed - 16'h0001;
endmodule

// ### testbench/fsc_top_chk.sv
// concurrent checks on the forced stop controller ports
`timescale 1ns/1ps
module fsc_top_chk
   import fsc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // drive side
   input  wire logic        i_forced_stop_in,
   input  wire logic        i_servo_on,
   input  wire logic        i_torque_mode,
   input  wire logic [15:0] i_motor_max_torque,
   // outputs
   input  wire fsc_cmd_t    o_cmd,
   input  wire logic        o_forced_stop_active,
   input  wire logic        o_panel_forced_stop_code,
   input  wire logic        o_hreadyout,
   input  wire logic        o_hresp
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // consecutive cycles with the contact open, saturating
   logic [3:0] low_cnt;
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         low_cnt <= 4'h0;
      else if (i_forced_stop_in)
         low_cnt <= 4'h0;
      else if (low_cnt != 4'hF)
         low_cnt <= low_cnt + 4'h1;

   sequence s_servo_held;
      i_servo_on [*8];
   endsequence
   sequence s_mode_held;
      i_torque_mode [*3];
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_panel_mirror: assert property (
      o_panel_forced_stop_code == o_forced_stop_active)
      else $error("panel code differs from stop state");
   a_drive_follows: assert property (
      (o_cmd.drive != FSC_DRV_RUN) == o_forced_stop_active)
      else $error("drive command disagrees with stop state");
   a_stop_cause: assert property (
      $rose(o_forced_stop_active) |-> low_cnt >= 4'h2)
      else $error("stop entered without a settled open contact");
   a_torque_clamp: assert property (
      o_forced_stop_active |-> o_cmd.torque_ceiling <= i_motor_max_torque)
      else $error("stop torque above motor maximum");
   a_torque_range: assert property (
      o_cmd.torque_ceiling <= 16'h0320)
      else $error("stop torque above 800 percent");
   a_no_torq_decel: assert property (
      s_mode_held |-> o_cmd.drive != FSC_DRV_DECEL)
      else $error("controlled stop in torque control");
   a_latch_holds: assert property (
      s_servo_held ##0 o_forced_stop_active |=> o_forced_stop_active)
      else $error("latched stop released without servo off");
   a_ramp_down: assert property (
      o_cmd.drive == FSC_DRV_DECEL && $past(o_cmd.drive) == FSC_DRV_DECEL
      |-> o_cmd.speed_ref <= $past(o_cmd.speed_ref))
      else $error("speed reference rose during stop");
   a_bus_okay: assert property (
      o_hreadyout && !o_hresp)
      else $error("bus slave not ready or not okay");
endmodule

bind fsc_top fsc_top_chk u_chk
(
   .i_clk                    (i_clk),
   .i_rst                    (i_rst),
   .i_forced_stop_in         (i_forced_stop_in),
   .i_servo_on               (i_servo_on),
   .i_torque_mode            (i_torque_mode),
   .i_motor_max_torque       (i_motor_max_torque),
   .o_cmd                    (o_cmd),
   .o_forced_stop_active     (o_forced_stop_active),
   .o_panel_forced_stop_code (o_panel_forced_stop_code),
   .o_hreadyout              (o_hreadyout),
   .o_hresp                  (o_hresp)
);

// ### testbench/fsc_top_tb.sv
// self-checking bench for the forced stop controller
`timescale 1ns/1ps
module fsc_top_tb
   import fsc_pkg::*;
;
   logic        clk, rst, hsel, hwrite, open_c, servo_req, restart, tmode;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic        hready, hresp, fsi, servo_on, act, panel, irq;
   logic [15:0] speed;
   logic [2:0]  live;
   fsc_cmd_t    cmd;
   int          num_errors, checks, cyc;

   fsc_host_model u_host (.i_clk(clk), .i_rst(rst), .i_open(open_c),
      .i_servo_req(servo_req), .i_run_speed(16'h0019), .i_cmd(cmd),
      .o_forced_stop_in(fsi), .o_servo_on(servo_on), .o_motor_speed(speed));

   fsc_top dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .i_forced_stop_in(fsi),
      .i_servo_on(servo_on), .i_restart(restart), .i_torque_mode(tmode),
      .i_motor_speed(speed), .i_max_speed(16'h0064),
      .i_motor_max_torque(16'h012C), .o_cmd(cmd),
      .o_forced_stop_active(act), .o_panel_forced_stop_code(panel),
      .o_irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task results;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard: the whole run needs well under half of this
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         num_errors++;
         $display("mismatch timeout expected finish seen hang");
         results;
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // single word transfer; the master waits for ready in both phases
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, r);
   endtask

   task cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   task wait_act(input logic v, input int lim);
      int i;
      i = 0;
      while (act !== v && i < lim)
      begin
         @(posedge clk);
         i++;
      end
      chk("stop_active", {31'h0, v}, {31'h0, act});
   endtask

   task t_regs;
      rdc("method", ADDR_METHOD, 32'h0000_0010);
      rdc("torque", ADDR_TORQUE, 32'h0000_0320);
      rdc("decel", ADDR_DECEL, 32'h0000_0000);
      rdc("unmapped", 8'h40, 32'h0000_0000);
      bus(1'b1, ADDR_TORQUE, 32'h0000_0384);
      rdc("torque_clamp", ADDR_TORQUE, 32'h0000_0320);
      chk("applied_torque", 32'h12C, {16'h0, cmd.torque_ceiling});
      bus(1'b1, ADDR_TORQUE, 32'h0000_0096);
      rdc("torque_set", ADDR_TORQUE, 32'h0000_0096);
      bus(1'b1, ADDR_DECEL, 32'h0000_4E20);
      rdc("decel_clamp", ADDR_DECEL, 32'h0000_2710);
      $display("test registers done");
   endtask

   task t_unassigned;
      bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
      servo_req <= 1'b1;
      open_c <= 1'b1;
      cycles(20);
      chk("unassigned_stop", 32'h0, {31'h0, act});
      open_c <= 1'b0;
      cycles(5);
      $display("test unassigned input done");
   endtask

   task run_method(input int m, input logic cs, input logic tm,
                   input logic [15:0] dms);
      fsc_drive_t fin;
      int         n;
      int         ex;
      fin = (!tm && (m == 2 || m == 4)) ? FSC_DRV_COAST
          : (cs ? FSC_DRV_COAST : FSC_DRV_BRAKE);
      ex = dms * CYC_PER_MS / 4;
      tmode <= tm;
      bus(1'b1, ADDR_DECEL, {16'h0, dms});
      bus(1'b1, ADDR_CONFIG, {30'h0, cs, 1'b1});
      bus(1'b1, ADDR_METHOD, 32'(m << METHOD_LSB));
      rdc("method_sel", ADDR_METHOD, 32'(m << METHOD_LSB));
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("method_live_old", {29'h0, live}, {29'h0, r[2:0]});
      restart <= 1'b1;
      cycles(1);
      restart <= 1'b0;
      cycles(2);
      live = m[2:0];
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("method_live_new", {29'h0, live}, {29'h0, r[2:0]});
      servo_req <= 1'b1;
      cycles(10);
      open_c <= 1'b1;
      wait_act(1'b1, 12);
      chk("panel_code", 32'h3, {30'h0, panel, cmd.panel_code});
      chk("decel", {31'h0, !tm && m != 0},
          {31'h0, cmd.drive === FSC_DRV_DECEL});
      if (!tm && (m == 1 || m == 2))
         chk("stop_torque", 32'h96, {16'h0, cmd.torque_ceiling});
      if (!tm && m >= 3 && dms == 0)
         chk("zero_speed", 32'h0, {16'h0, cmd.speed_ref});
      n = 0;
      while (cmd.drive !== fin && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      chk("drive_after", {30'h0, fin}, {30'h0, cmd.drive});
      if (dms != 0)
         chk("ramp_time", 32'h1,
             {31'h0, n > ex - ex / 20 && n < ex + ex / 20});
      open_c <= 1'b0;
      cycles(12);
      chk("latched", 32'h1, {31'h0, act});
      servo_req <= 1'b0;
      cycles(6);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("base_block", 32'h4, {29'h0, r[5:3]});
      chk("still_active", 32'h1, {31'h0, act});
      servo_req <= 1'b1;
      wait_act(1'b0, 12);
      chk("drive_run", {30'h0, FSC_DRV_RUN}, {30'h0, cmd.drive});
      $display("test method %0d done", m);
   endtask

   task t_irq;
      bus(1'b1, ADDR_IRQ_CLR, 32'h3);
      bus(1'b1, ADDR_IRQ_EN, 32'h1);
      cycles(2);
      chk("irq_idle", 32'h0, {31'h0, irq});
      run_method(0, 1'b0, 1'b0, 16'h0);
      chk("irq_raised", 32'h1, {31'h0, irq});
      rdc("irq_status", ADDR_IRQ_ST, 32'h3);
      bus(1'b1, ADDR_IRQ_CLR, 32'h1);
      cycles(2);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, ADDR_IRQ_EN, 32'h2);
      cycles(2);
      chk("irq_enabled", 32'h1, {31'h0, irq});
      bus(1'b1, ADDR_IRQ_CLR, 32'h2);
      cycles(2);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      rdc("irq_empty", ADDR_IRQ_ST, 32'h0);
      $display("test interrupts done");
   endtask

   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      open_c = 1'b0;
      servo_req = 1'b0;
      restart = 1'b0;
      tmode = 1'b0;
      live = 3'h1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_unassigned;
      for (int m = 0; m < 5; m++)
         for (int c = 0; c < 2; c++)
            run_method(m, c[0], 1'b0, 16'h0);
      run_method(3, 1'b0, 1'b1, 16'h0);
      run_method(4, 1'b0, 1'b1, 16'h0);
      run_method(3, 1'b1, 1'b0, 16'h1);
      t_irq;
      results;
   end
endmodule
